// ===== src/scs_pkg.sv
/*
 system clock switch controller: shared constants, codes and types.
 assumes a single system clock domain and an Avalon-MM register bus.
*/

package scs_pkg;

   // ----------------------------------------------------------------
   // register map (word indices, matched against address bits 3:2) and control word fields
   // ----------------------------------------------------------------
   localparam logic [1:0] SCS_IDX_CTRL = 2'h0;
   localparam logic [1:0] SCS_IDX_KEY = 2'h1;
   localparam int SCS_CUR_LSB = 12;
   localparam int SCS_NEW_LSB = 8;
   localparam int SCS_LOCK_BIT = 5;
   localparam int SCS_FAIL_BIT = 3;
   localparam int SCS_KEEP_BIT = 1;
   localparam int SCS_REQ_BIT = 0;

   // ----------------------------------------------------------------
   // source codes, oscillator slots, submodes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SCS_SRC_FAST_RC = 3'h0,
      SCS_SRC_FAST_RC_MUL = 3'h1,
      SCS_SRC_PRIMARY = 3'h2,
      SCS_SRC_PRIMARY_MUL = 3'h3,
      SCS_SRC_SECONDARY = 3'h4,
      SCS_SRC_LOW_POWER_RC = 3'h5
   } scs_src_t;
   localparam int SCS_OSC_PRI = 0;
   localparam int SCS_OSC_SEC = 1;
   localparam int SCS_OSC_FAST = 2;
   localparam int SCS_OSC_LOW = 3;
   localparam logic [1:0] SCS_SUB_EXT_CLK = 2'h0;

   // ----------------------------------------------------------------
   // reset values, keys (arbitrary values), counts
   // ----------------------------------------------------------------
   localparam logic [2:0] SCS_CUR_RST = 3'h0;
   localparam logic [3:0] SCS_OSC_RST = 4'h4;
   localparam logic [7:0] SCS_KEY_FIRST = 8'h5a;
   localparam logic [7:0] SCS_KEY_SECOND = 8'hc3;
   localparam int SCS_NEW_CLK_COUNT = 10;
   localparam int SCS_OST_CYCLES = 1024;

   typedef enum logic [1:0] {
      SCS_ST_IDLE = 2'b00,
      SCS_ST_CHECK = 2'b01,
      SCS_ST_READY_WAIT = 2'b10,
      SCS_ST_COUNT = 2'b11
   } scs_state_t;

endpackage : scs_pkg

// ===== src/scs_unlock_if.sv
/*
 carrier between the controller core and its unlock key checker.
 assumes all signals are synchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

interface scs_unlock_if;
   logic key_wr;
   logic [7:0] key_data;
   logic other_wr;
   logic grant;
   modport checker_side (input key_wr, input key_data, input other_wr, output grant);
   modport core_side (output key_wr, output key_data, output other_wr, input grant);
endinterface : scs_unlock_if

`default_nettype wire

// ===== src/scs_unlock.sv
/*
 unlock key checker: two key writes in a row open one control write.
 assumes key and other writes never come in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module scs_unlock
   import scs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   scs_unlock_if.checker_side ul
);

   // ----------------------------------------------------------------
   // key stage: 0 none, 1 first key seen, 2 unlocked
   // ----------------------------------------------------------------
   logic [1:0] stage;
   logic [1:0] next_stage;
   wire logic first_ok = ul.key_data == SCS_KEY_FIRST;
   wire logic second_ok = (ul.key_data == SCS_KEY_SECOND) && (stage == 2'd1);

   // any non-key write consumes or breaks the sequence
   assign next_stage = ul.other_wr ? 2'd0 :
                       !ul.key_wr ? stage :
                       second_ok ? 2'd2 :
                       first_ok ? 2'd1 : 2'd0;

   // stage register
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         stage <= 2'd0;
      else if (ce)
         stage <= next_stage;
   end

   assign ul.grant = stage == 2'd2;

endmodule : scs_unlock

`default_nettype wire

// ===== src/scs_wait_counter.sv
/*
 wait counter: counts tick pulses after start and raises done at limit.
 assumes limit is held stable while running and is at least one.
*/
`timescale 1ns/1ps
`default_nettype none

module scs_wait_counter #(
   parameter int WIDTH = 16
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic start,
   input wire logic tick,
   input wire logic [WIDTH-1:0] limit,
   output logic done
);

   // elaboration check: a one-bit counter cannot hold limit minus one
   if (WIDTH < 2)
   begin : g_bad_width
      $error("counter width too small");
   end

   logic [WIDTH-1:0] cnt;
   logic run;
   wire logic last = cnt == (limit - {{(WIDTH-1){1'b0}}, 1'b1});

   // count ticks while running, stop and flag at limit
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         cnt <= '0;
         run <= 1'b0;
         done <= 1'b0;
      end
      else if (ce)
      begin
         if (start)
         begin
            cnt <= '0;
            run <= 1'b1;
            done <= 1'b0;
         end
         else if (run && tick)
         begin
            cnt <= cnt + {{(WIDTH-1){1'b0}}, 1'b1};
            run <= !last;
            done <= last;
         end
      end
   end

endmodule : scs_wait_counter

`default_nettype wire

// ===== src/scs_clock_switch.sv
/*
 system clock switch controller top: register slave, switch sequencer,
 oscillator enables. assumes configuration inputs are static straps,
 new_clk_tick is one sys_clk pulse per cycle of the target clock,
 and all inputs are synchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module scs_clock_switch
   import scs_pkg::*;
#(
   parameter int OST_CYCLES = SCS_OST_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic switch_monitor_cfg,
   input wire logic [2:0] initial_source_cfg,
   input wire logic [1:0] primary_submode_cfg,
   input wire logic watchdog_en,
   input wire logic pll_lock,
   input wire logic clock_fail_event,
   input wire logic new_clk_tick,
   output logic [2:0] clk_select,
   output logic [3:0] osc_enable,
   output logic pll_enable,
   output logic switch_busy
);

   // elaboration check: the start-up count must fit the 16-bit counter
   if (OST_CYCLES < 1 || OST_CYCLES > 65535)
   begin : g_bad_ost
      $error("start-up count out of range");
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [3:0] osc_mask(input logic [2:0] s);
      logic [3:0] m;
      m = 4'h0;
      case (s)
         SCS_SRC_PRIMARY, SCS_SRC_PRIMARY_MUL: m[SCS_OSC_PRI] = 1'b1;
         SCS_SRC_SECONDARY: m[SCS_OSC_SEC] = 1'b1;
         SCS_SRC_LOW_POWER_RC: m[SCS_OSC_LOW] = 1'b1;
         default: m[SCS_OSC_FAST] = 1'b1;
      endcase
      return m;
   endfunction : osc_mask

   function automatic logic uses_mul(input logic [2:0] s);
      return (s == SCS_SRC_FAST_RC_MUL) || (s == SCS_SRC_PRIMARY_MUL);
   endfunction : uses_mul

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   scs_state_t state;
   scs_state_t next_state;
   logic [2:0] new_src;
   logic req_bit;
   logic lock_bit;
   logic fail_bit;
   logic keep_bit;
   logic need_ost;
   logic ost_done;
   logic cnt_done;

   scs_unlock_if ul ();

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   // the bus keeps answering during a switch, so code keeps running
   wire logic bus_req = avs_read | avs_write;
   wire logic first_edge = bus_req && avs_waitrequest;
   wire logic wr_accept = avs_write && !avs_waitrequest;
   wire logic sel_ctrl = avs_address[3:2] == SCS_IDX_CTRL;
   wire logic sel_key = avs_address[3:2] == SCS_IDX_KEY;
   wire logic key_wr = wr_accept && sel_key && avs_byteenable[0];
   wire logic hi_wr = wr_accept && sel_ctrl && avs_byteenable[1] && ul.grant;
   wire logic lo_wr = wr_accept && sel_ctrl && avs_byteenable[0] && ul.grant;
   wire logic sw_en = !switch_monitor_cfg;

   assign ul.key_wr = key_wr;
   assign ul.key_data = avs_writedata[7:0];
   assign ul.other_wr = wr_accept && !key_wr;

   // control word image; bit 14:12 current, 10:8 new
   wire logic [15:0] ctrl_word = {1'b0, clk_select, 1'b0, new_src, 2'b00, lock_bit,
                                  1'b0, fail_bit, 1'b0, keep_bit, req_bit & sw_en};
   wire logic [31:0] read_mux = sel_ctrl ? {16'h0000, ctrl_word} : 32'h0000_0000;

   // ----------------------------------------------------------------
   // switch decisions
   // ----------------------------------------------------------------
   wire logic tgt_valid = new_src <= SCS_SRC_LOW_POWER_RC;
   wire logic same_src = new_src == clk_select;
   wire logic go_switch = (state == SCS_ST_CHECK) && tgt_valid && !same_src;
   wire logic abort_switch = (state == SCS_ST_CHECK) && !go_switch;
   wire logic [3:0] tgt_mask = osc_mask(new_src);
   wire logic tgt_mul = uses_mul(new_src);
   // the submode is a strap only: external clock needs no start-up wait
   wire logic primary_xtal = primary_submode_cfg != SCS_SUB_EXT_CLK;
   wire logic tgt_xtal = (tgt_mask[SCS_OSC_SEC]) || (tgt_mask[SCS_OSC_PRI] && primary_xtal);
   wire logic tgt_off = (tgt_mask & osc_enable) == 4'h0;
   wire logic ost_start = go_switch && tgt_xtal && tgt_off;
   wire logic tgt_ready = (!need_ost || ost_done) && (!tgt_mul || lock_bit);
   wire logic cnt_start = (state == SCS_ST_READY_WAIT) && tgt_ready;
   wire logic finish = (state == SCS_ST_COUNT) && cnt_done;
   wire logic keep_low = watchdog_en || sw_en;
   wire logic [3:0] keep_mask = tgt_mask | {keep_low, 1'b0, keep_bit, 1'b0};
   wire logic [3:0] init_mask = osc_mask(initial_source_cfg) | {watchdog_en, 3'b000};

   // sequencer next state
   always_comb
   begin
      next_state = state;
      unique case (state)
         SCS_ST_IDLE:
            if (req_bit && sw_en)
               next_state = SCS_ST_CHECK;
         SCS_ST_CHECK:
            next_state = go_switch ? SCS_ST_READY_WAIT : SCS_ST_IDLE;
         SCS_ST_READY_WAIT:
            if (tgt_ready)
               next_state = SCS_ST_COUNT;
         SCS_ST_COUNT:
            if (cnt_done)
               next_state = SCS_ST_IDLE;
      endcase
   end

   // request bit: set by unlocked low-byte write, cleared by hardware
   wire logic req_set = lo_wr && avs_writedata[SCS_REQ_BIT] && sw_en && (state == SCS_ST_IDLE);
   wire logic next_req = (req_bit && !abort_switch && !finish) || req_set;
   // fail flag: event wins over both clears
   wire logic fail_clr = go_switch || (lo_wr && !avs_writedata[SCS_FAIL_BIT]);
   wire logic next_fail = (fail_bit && !fail_clr) || (clock_fail_event && sw_en);
   wire logic next_lock = !go_switch && pll_lock && pll_enable;
   wire logic next_pll = sw_en ? (go_switch ? tgt_mul | pll_enable :
                         finish ? tgt_mul : pll_enable) : uses_mul(initial_source_cfg);

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   // bus handshake: one wait cycle, read data captured at the first edge
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end
      else if (ce)
      begin
         avs_waitrequest <= !first_edge;
         if (first_edge && avs_read)
            avs_readdata <= read_mux;
      end
   end

   // control fields written by software
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         new_src <= SCS_CUR_RST;
         keep_bit <= 1'b0;
      end
      else if (ce)
      begin
         if (hi_wr)
            new_src <= avs_writedata[SCS_NEW_LSB +: 3];
         if (lo_wr)
            keep_bit <= avs_writedata[SCS_KEEP_BIT];
      end
   end

   // status bits and sequencer
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         state <= SCS_ST_IDLE;
         req_bit <= 1'b0;
         fail_bit <= 1'b0;
         lock_bit <= 1'b0;
         need_ost <= 1'b0;
         pll_enable <= 1'b0;
         switch_busy <= 1'b0;
      end
      else if (ce)
      begin
         state <= next_state;
         req_bit <= next_req;
         fail_bit <= next_fail;
         lock_bit <= next_lock;
         pll_enable <= next_pll;
         switch_busy <= next_state != SCS_ST_IDLE;
         if (go_switch)
            need_ost <= ost_start;
      end
   end

   // current source and oscillator enables
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         clk_select <= SCS_CUR_RST;
         osc_enable <= SCS_OSC_RST;
      end
      else if (ce)
      begin
         if (!sw_en)
         begin
            clk_select <= initial_source_cfg;
            osc_enable <= init_mask;
         end
         else if (go_switch)
            osc_enable <= osc_enable | tgt_mask;
         else if (finish)
         begin
            clk_select <= new_src;
            osc_enable <= keep_mask;
         end
      end
   end

   // ----------------------------------------------------------------
   // sub-blocks
   // ----------------------------------------------------------------
   scs_unlock u_unlock (
      .sys_clk(sys_clk),
      .rst(rst),
      .ce(ce),
      .ul(ul.checker_side)
   );

   scs_wait_counter #(.WIDTH(16)) u_ost (
      .sys_clk(sys_clk),
      .rst(rst),
      .ce(ce),
      .start(ost_start),
      .tick(1'b1),
      .limit(16'(OST_CYCLES)),
      .done(ost_done)
   );

   scs_wait_counter #(.WIDTH(16)) u_new_clk (
      .sys_clk(sys_clk),
      .rst(rst),
      .ce(ce),
      .start(cnt_start),
      .tick(new_clk_tick),
      .limit(16'(SCS_NEW_CLK_COUNT)),
      .done(cnt_done)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [4:0] tick_seen;
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         tick_seen <= 5'd0;
      else if (ce)
         tick_seen <= (state != SCS_ST_COUNT) ? 5'd0 : tick_seen + 5'(new_clk_tick);
   end

   req_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
      !sw_en |-> (!ctrl_word[SCS_REQ_BIT] && !req_bit && state == SCS_ST_IDLE))
      else $error("request bit visible while switching is off");
   cur_follow_a: assert property (@(posedge sys_clk) disable iff (rst)
      (!sw_en && ce && !rst) |=> clk_select == $past(initial_source_cfg))
      else $error("current source does not follow initial config");
   abort_same_a: assert property (@(posedge sys_clk) disable iff (rst)
      (state == SCS_ST_CHECK && same_src && ce) |=> (state == SCS_ST_IDLE && !req_bit))
      else $error("redundant switch not aborted");
   start_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
      (go_switch && ce && !clock_fail_event) |=> (!lock_bit && !fail_bit))
      else $error("lock or fail flag not cleared at switch start");
   ost_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
      (state == SCS_ST_READY_WAIT && need_ost && !ost_done) |=> state != SCS_ST_COUNT)
      else $error("crystal target used before start-up timer");
   lock_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
      (state == SCS_ST_READY_WAIT && tgt_mul && !lock_bit) |=> state == SCS_ST_READY_WAIT)
      else $error("multiplier target used before lock");
   ten_ticks_a: assert property (@(posedge sys_clk) disable iff (rst)
      finish |-> tick_seen == 5'd10)
      else $error("switch not after ten new clock cycles");
   finish_copy_a: assert property (@(posedge sys_clk) disable iff (rst)
      (finish && ce) |=> (clk_select == $past(new_src) && !req_bit && !switch_busy))
      else $error("completion did not copy source or clear request");
   old_off_a: assert property (@(posedge sys_clk) disable iff (rst)
      (finish && ce && !keep_bit) |=> !osc_enable[SCS_OSC_SEC] || clk_select == SCS_SRC_SECONDARY)
      else $error("old secondary oscillator left running");
   locked_wr_a: assert property (@(posedge sys_clk) disable iff (rst)
      (wr_accept && sel_ctrl && !ul.grant && ce) |=> $stable(new_src))
      else $error("control write accepted without unlock");

   abort_c: cover property (@(posedge sys_clk) disable iff (rst) abort_switch && ce);
   switch_c: cover property (@(posedge sys_clk) disable iff (rst) finish && ce);
   ost_c: cover property (@(posedge sys_clk) disable iff (rst) ost_start && ce);

endmodule : scs_clock_switch

`default_nettype wire

// ===== test/tb_scs_clock_switch.sv
/*
 testbench for scs_clock_switch: avalon master, tick source, readback queue.
 assumes static configuration straps; bus waits end on waitrequest low.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_scs_clock_switch
   import scs_pkg::*;
;
   // ----------------------------------------------------------------
   // stimulus signals and bookkeeping
   // ----------------------------------------------------------------
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic cfg_off = 1'b1;
   logic [2:0] init_src = 3'h4;
   logic pll_lock = 1'b1;
   logic fail_ev = 1'b0;
   logic rnd_tick = 1'b0;
   logic man_tick = 1'b0;
   logic tick_man = 1'b0;
   logic [2:0] clk_select;
   logic [3:0] osc_enable;
   logic pll_enable;
   logic switch_busy;
   logic [15:0] lfsr = 16'h14e1;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   int bad_count = 0;
   int checks_done = 0;
   localparam logic [31:0] FULL = 32'hffff_772b;

   always #12.5 sys_clk = ~sys_clk;

   scs_clock_switch #(.OST_CYCLES(4)) dut_u (
      .sys_clk(sys_clk), .rst(rst), .ce(1'b1), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .switch_monitor_cfg(cfg_off),
      .initial_source_cfg(init_src), .primary_submode_cfg(2'h1), .watchdog_en(1'b0),
      .pll_lock(pll_lock), .clock_fail_event(fail_ev),
      .new_clk_tick(tick_man ? man_tick : rnd_tick), .clk_select(clk_select),
      .osc_enable(osc_enable), .pll_enable(pll_enable), .switch_busy(switch_busy));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] lfsr_next(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction : lfsr_next

   function automatic logic [31:0] word(input logic [2:0] cur, input logic [2:0] nw,
      input int lk, input int fl, input int kp, input int rq);
      return {16'h0000, 1'b0, cur, 1'b0, nw, 2'b00, lk[0], 1'b0, fl[0], 1'b0, kp[0], rq[0]};
   endfunction : word

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test

   // random tick pulses standing in for the new clock
   always @(posedge sys_clk)
   begin
      rnd_tick <= lfsr[0];
      lfsr <= lfsr_next(lfsr);
   end

   // read watcher: oldest note against the returned word
   always @(posedge sys_clk)
      if (avs_read && avs_waitrequest === 1'b0)
      begin
         cmp(avs_readdata & msk_q[0], exp_q[0] & msk_q[0]);
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end

   // one avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] be);
      @(posedge sys_clk);
      avs_read <= rd;
      avs_write <= !rd;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      // only the watchdog ends a wait that never answers
      do
         @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      bus(1'b1, a, 32'h0000_0000, 4'hf);
   endtask : rd

   // unlocked control write
   task automatic ctl(input logic [31:0] d, input logic [3:0] be);
      bus(1'b0, 4'h4, {24'h00_0000, SCS_KEY_FIRST}, 4'h1);
      bus(1'b0, 4'h4, {24'h00_0000, SCS_KEY_SECOND}, 4'h1);
      bus(1'b0, 4'h0, d, be);
   endtask : ctl

   // high byte new source, then low byte with the request
   task automatic sw(input logic [2:0] src, input logic [7:0] lo);
      ctl({21'h00_0000, src, 8'h00}, 4'h2);
      ctl({24'h00_0000, lo}, 4'h1);
   endtask : sw

   task automatic wait_idle();
      repeat (3) @(posedge sys_clk);
      while (switch_busy !== 1'b0)
         @(posedge sys_clk);
   endtask : wait_idle

   task automatic do_reset();
      rst <= 1'b1;
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
   endtask : do_reset

   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial
   begin
      do_reset();
      repeat (2) @(posedge sys_clk);
      cmp(32'(clk_select), 32'h0000_0004);
      cmp(32'(osc_enable), 32'h0000_0002);
      sw(3'h2, 8'h01);
      wait_idle();
      rd(4'h0, word(3'h4, 3'h0, 0, 0, 0, 0), 32'hffff_7001);
      cmp(32'(clk_select), 32'h0000_0004);
      $display("switching disabled test done");
      cfg_off <= 1'b0;
      do_reset();
      rd(4'h8, 32'h0000_0000, 32'hffff_ffff);
      bus(1'b0, 4'h0, 32'h0000_0200, 4'h2);
      rd(4'h0, word(3'h0, 3'h0, 0, 0, 0, 0), FULL);
      sw(3'h0, 8'h01);
      wait_idle();
      rd(4'h0, word(3'h0, 3'h0, 0, 0, 0, 0), FULL);
      // an invalid source code is aborted like a redundant one
      sw(3'h6, 8'h01);
      wait_idle();
      rd(4'h0, word(3'h0, 3'h6, 0, 0, 0, 0), FULL);
      $display("lock and redundant test done");
      sw(3'h2, 8'h01);
      wait_idle();
      rd(4'h0, word(3'h2, 3'h2, 0, 0, 0, 0), FULL);
      cmp(32'(osc_enable), 32'h0000_0009);
      pll_lock <= 1'b0;
      sw(3'h3, 8'h01);
      repeat (40) @(posedge sys_clk);
      cmp(32'(switch_busy), 32'h0000_0001);
      cmp(32'(clk_select), 32'h0000_0002);
      pll_lock <= 1'b1;
      wait_idle();
      cmp(32'(pll_enable), 32'h0000_0001);
      rd(4'h0, word(3'h3, 3'h3, 1, 0, 0, 0), FULL);
      $display("primary and multiplier test done");
      @(posedge sys_clk);
      fail_ev <= 1'b1;
      @(posedge sys_clk);
      fail_ev <= 1'b0;
      rd(4'h0, word(3'h3, 3'h3, 1, 1, 0, 0), FULL);
      sw(3'h4, 8'h0b);
      wait_idle();
      rd(4'h0, word(3'h4, 3'h4, 0, 0, 1, 0), FULL);
      cmp(32'(osc_enable), 32'h0000_000a);
      $display("secondary keep test done");
      tick_man <= 1'b1;
      sw(3'h5, 8'h01);
      repeat (20) @(posedge sys_clk);
      repeat (9)
      begin
         @(posedge sys_clk);
         man_tick <= 1'b1;
         @(posedge sys_clk);
         man_tick <= 1'b0;
      end
      repeat (6) @(posedge sys_clk);
      cmp(32'(clk_select), 32'h0000_0004);
      @(posedge sys_clk);
      man_tick <= 1'b1;
      @(posedge sys_clk);
      man_tick <= 1'b0;
      repeat (4) @(posedge sys_clk);
      cmp(32'(clk_select), 32'h0000_0005);
      cmp(32'(osc_enable), 32'h0000_0008);
      rd(4'h0, word(3'h5, 3'h5, 0, 0, 0, 0), FULL);
      $display("ten tick test done");
      repeat (4) @(posedge sys_clk);
      finish_test();
   end

   // watchdog against a hung handshake or sequence
   initial
   begin
      #750000;
      bad_count++;
      finish_test();
   end

endmodule : tb_scs_clock_switch

`default_nettype wire
